/* exc_vector_pkg.sv */
package exc_vector_pkg;

  // Vector page and line layout: line k stands for vector page:2k
  localparam logic [7:0] VEC_PAGE = 8'hff;
  localparam int NUM_LINES = 128;
  localparam int NUM_PERIPH = 121;
  localparam int NUM_INT_LINES = 123;
  localparam logic [6:0] IDX_IRQ = 7'h79;
  localparam logic [6:0] IDX_NONMASKABLE_PIN_REQUEST = 7'h7a;
  localparam logic [6:0] IDX_SWI = 7'h7b;
  localparam logic [6:0] IDX_TRAP = 7'h7c;
  localparam logic [6:0] IDX_COP = 7'h7d;
  localparam logic [6:0] IDX_CRYSTAL = 7'h7e;
  localparam logic [6:0] IDX_POR = 7'h7f;
  localparam logic [7:0] SOFTWARE_TRAP_VECTOR = 8'hf6;

  // Promotion selector layout and reset value
  localparam logic [7:0] PROMO_RESET = 8'hf2;
  localparam logic [7:0] PROMO_LIMIT = 8'hf2;

  // Test control layout
  localparam int OVERRIDE_BIT = 4;
  localparam logic [3:0] ADR_RESET = 4'h0;
  localparam logic [7:0] CTRL_MASK = 8'h1f;

  // Reset requests from the system reset decoder
  typedef struct packed {
    logic por;
    logic crystal;
    logic watchdog_reset_request;
  } reset_req_t;

  // Test access strobe group
  typedef struct packed {
    logic wr;
    logic rd;
    logic sel_bits;
    logic [7:0] wdata;
  } test_access_t;

endpackage

/* maskable_promotion.sv */
`timescale 1ns/1ps
module maskable_promotion #(
  parameter bit PROMO_EN = 1'b1,
  parameter logic [120:0] IMPL_MASK = {121{1'b1}}
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Selector write from software, allowed only with maskables masked
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic i_mask,
  // Promotion result
  output logic [6:0] promo_index,
  output logic [7:0] rdata
);

  logic [7:0] maskable_promotion_select; // Stored selector, bit 0 always zero

  // Selector store; writes ignored while maskable interrupts are enabled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      maskable_promotion_select <= exc_vector_pkg::PROMO_RESET;
    else if (PROMO_EN && wr && i_mask)
      maskable_promotion_select <= {wdata[7:1], 1'b0};
  end

  // Decode to a line index; anything unusable falls back to the pin
  always_comb
  begin
    promo_index = exc_vector_pkg::IDX_IRQ;
    if (!PROMO_EN)
      promo_index = exc_vector_pkg::IDX_IRQ;
    else if (maskable_promotion_select < exc_vector_pkg::PROMO_LIMIT &&
             IMPL_MASK[maskable_promotion_select[7:1]])
      promo_index = maskable_promotion_select[7:1];
    else
      promo_index = exc_vector_pkg::IDX_IRQ;
  end

  assign rdata = PROMO_EN ? maskable_promotion_select : 8'h00;

endmodule

/* exception_vector_priority_decoder.sv */
`timescale 1ns/1ps
module exception_vector_priority_decoder #(
  parameter bit PROMO_EN = 1'b1,
  parameter logic [120:0] IMPL_MASK = {121{1'b1}}
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Mode and CPU mask state
  input wire logic SPECIAL_MODE,
  input wire logic I_MASK,
  input wire logic X_MASK,
  // Exception sources
  input wire exc_vector_pkg::reset_req_t RESET_REQ,
  input wire logic TRAP_REQ,
  input wire logic SWI_REQ,
  input wire logic BACKGROUND_DEBUG_REQUEST,
  input wire logic NONMASKABLE_PIN_REQUEST,
  input wire logic IRQ_PIN_REQ,
  input wire logic [120:0] PERIPH_REQ,
  // Promotion selector write
  input wire logic PROMO_WR,
  input wire logic [7:0] PROMO_WDATA,
  output logic [7:0] PROMO_RDATA,
  // Test register access
  input wire exc_vector_pkg::test_access_t TEST_ACC,
  output logic [7:0] TEST_RDATA,
  // CPU vector fetch
  input wire logic VECTOR_REQ,
  output logic [15:0] VECTOR,
  output logic VECTOR_VALID,
  output logic INT_PENDING,
  // Wake-up while clocks are stopped
  output logic WAKEUP
);

  logic test_input_override; // Test bits drive the decoder when set
  logic [3:0] test_adr; // Test group select
  logic [122:0] interrupt_test_bits; // Forced interrupt lines
  logic [122:0] raw_lines; // Real interrupt inputs
  logic [122:0] int_lines; // Lines seen by the decoder
  logic [127:0] valid; // Valid requests, indexed by vector
  logic [6:0] promo_index; // Promoted maskable line
  logic [7:0] promo_rdata; // Selector readback
  logic [6:0] top_index; // Plain highest valid line
  logic [6:0] win_index; // Winner after promotion
  logic any_valid; // Some valid request exists
  logic [6:0] last_index; // Last valid winner seen
  logic seen; // Helper: some request has been valid
  logic [127:0] rd_lines; // Padded readback source

  // Promotion selector and decode
  maskable_promotion #(
    .PROMO_EN(PROMO_EN),
    .IMPL_MASK(IMPL_MASK)
  ) u_promo (
    .clk(REF_CLK),
    .rst(RST),
    .wr(PROMO_WR),
    .wdata(PROMO_WDATA),
    .i_mask(I_MASK),
    .promo_index(promo_index),
    .rdata(promo_rdata)
  );

  // Interrupt inputs, or test bits under override
  assign raw_lines = {NONMASKABLE_PIN_REQUEST, IRQ_PIN_REQ, PERIPH_REQ};
  assign int_lines = test_input_override ? interrupt_test_bits : raw_lines;

  // Integer views of the fixed line indices, declared before the logic that indexes with them
  localparam int IDX_IRQ_C = exc_vector_pkg::IDX_IRQ;
  localparam int IDX_NONMASKABLE_PIN_REQUEST_C = exc_vector_pkg::IDX_NONMASKABLE_PIN_REQUEST;
  localparam int IDX_SWI_C = exc_vector_pkg::IDX_SWI;
  localparam int IDX_TRAP_C = exc_vector_pkg::IDX_TRAP;
  localparam int IDX_COP_C = exc_vector_pkg::IDX_COP;
  localparam int IDX_CM_C = exc_vector_pkg::IDX_CRYSTAL;
  localparam int IDX_POR_C = exc_vector_pkg::IDX_POR;

  // Validity: maskables need I clear, the nonmaskable pin needs X clear
  always_comb
  begin
    valid = '0;
    valid[120:0] = int_lines[120:0] & {121{~I_MASK}};
    valid[IDX_IRQ_C] = int_lines[IDX_IRQ_C] & ~I_MASK;
    valid[IDX_NONMASKABLE_PIN_REQUEST_C] = int_lines[IDX_NONMASKABLE_PIN_REQUEST_C] & ~X_MASK;
    valid[IDX_SWI_C] = SWI_REQ | BACKGROUND_DEBUG_REQUEST;
    valid[IDX_TRAP_C] = TRAP_REQ;
    valid[IDX_COP_C] = RESET_REQ.watchdog_reset_request;
    valid[IDX_CM_C] = RESET_REQ.crystal;
    valid[IDX_POR_C] = RESET_REQ.por;
  end

  // Highest vector wins; the line order is the priority order
  always_comb
  begin
    top_index = exc_vector_pkg::IDX_SWI;
    any_valid = 1'b0;
    for (int k = 0; k < exc_vector_pkg::NUM_LINES; k++)
    begin
      if (valid[k])
      begin
        top_index = 7'(k);
        any_valid = 1'b1;
      end
    end
  end

  // Promoted source beats other maskables but nothing above the pin
  always_comb
  begin
    if (top_index <= exc_vector_pkg::IDX_IRQ && valid[promo_index])
      win_index = promo_index;
    else
      win_index = top_index;
  end

  // Remember the last valid winner; reset value is the software trap line
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      last_index <= exc_vector_pkg::IDX_SWI;
    else if (any_valid)
      last_index <= win_index;
  end

  // Helper for checks: has anything ever been valid
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      seen <= 1'b0;
    else if (any_valid)
      seen <= 1'b1;
  end

  // Vector answer; the winner is taken at the request edge, not earlier
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      VECTOR <= {exc_vector_pkg::VEC_PAGE, exc_vector_pkg::SOFTWARE_TRAP_VECTOR};
      VECTOR_VALID <= 1'b0;
    end
    else
    begin
      VECTOR_VALID <= VECTOR_REQ;
      if (VECTOR_REQ)
      begin
        if (any_valid)
          VECTOR <= {exc_vector_pkg::VEC_PAGE, win_index, 1'b0};
        else
          VECTOR <= {exc_vector_pkg::VEC_PAGE, last_index, 1'b0};
      end
    end
  end

  // Pending flag toward the CPU
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      INT_PENDING <= 1'b0;
    else
      INT_PENDING <= |valid[IDX_NONMASKABLE_PIN_REQUEST_C:0];
  end

  // Promotion readback register
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      PROMO_RDATA <= exc_vector_pkg::PROMO_RESET;
    else
      PROMO_RDATA <= promo_rdata;
  end

  // Test control: only in special mode; override needs both masks set
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      test_input_override <= 1'b0;
      test_adr <= exc_vector_pkg::ADR_RESET;
    end
    else if (SPECIAL_MODE && TEST_ACC.wr && !TEST_ACC.sel_bits)
    begin
      test_adr <= TEST_ACC.wdata[3:0];
      if (I_MASK && X_MASK)
        test_input_override <= TEST_ACC.wdata[exc_vector_pkg::OVERRIDE_BIT];
    end
  end

  // Test bits: eight lines per group, lines above the pin not writable
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      interrupt_test_bits <= '0;
    else if (SPECIAL_MODE && TEST_ACC.wr && TEST_ACC.sel_bits && test_input_override && I_MASK)
    begin
      for (int k = 0; k < 8; k++)
      begin
        if (int'(test_adr) * 8 + k < exc_vector_pkg::NUM_INT_LINES)
          interrupt_test_bits[int'(test_adr) * 8 + k] <= TEST_ACC.wdata[k];
      end
    end
  end

  // Test readback; normal mode always reads zero
  assign rd_lines = {5'h00, int_lines};
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      TEST_RDATA <= 8'h00;
    else if (!SPECIAL_MODE)
      TEST_RDATA <= 8'h00;
    else if (TEST_ACC.rd)
    begin
      if (TEST_ACC.sel_bits)
        TEST_RDATA <= rd_lines[{test_adr, 3'h0} +: 8];
      else
        TEST_RDATA <= {3'h0, test_input_override, test_adr} & exc_vector_pkg::CTRL_MASK;
    end
  end

  // Wake-up must work with clocks stopped, so this one is not registered
  assign WAKEUP = (|valid[IDX_IRQ_C:0]) | int_lines[IDX_NONMASKABLE_PIN_REQUEST_C];

  // Checks
  a_answer_follows_req: assert property (@(posedge REF_CLK) disable iff (RST)
    VECTOR_REQ |=> VECTOR_VALID)
    else $error("no answer after vector request");
  a_answer_has_cause: assert property (@(posedge REF_CLK) disable iff (RST)
    VECTOR_VALID |-> $past(VECTOR_REQ))
    else $error("answer without request");
  a_por_top_vector: assert property (@(posedge REF_CLK) disable iff (RST)
    VECTOR_REQ && RESET_REQ.por |=> VECTOR == 16'hfffe)
    else $error("power-on reset did not win");
  a_watchdog_vector: assert property (@(posedge REF_CLK) disable iff (RST)
    VECTOR_REQ && RESET_REQ.watchdog_reset_request && !RESET_REQ.por && !RESET_REQ.crystal
    |=> VECTOR == 16'hfffa)
    else $error("watchdog vector wrong");
  a_never_pending_swi: assert property (@(posedge REF_CLK) disable iff (RST)
    VECTOR_REQ && !any_valid && !seen |=> VECTOR == 16'hfff6)
    else $error("default vector is not the software trap");
  a_last_valid_kept: assert property (@(posedge REF_CLK) disable iff (RST)
    VECTOR_REQ && !any_valid |=> VECTOR[7:1] == $past(last_index))
    else $error("last valid vector not used");
  a_mask_blocks_i: assert property (@(posedge REF_CLK) disable iff (RST)
    VECTOR_REQ && I_MASK && any_valid |=> VECTOR[7:1] >= exc_vector_pkg::IDX_NONMASKABLE_PIN_REQUEST)
    else $error("masked source won");
  a_promo_wins: assert property (@(posedge REF_CLK) disable iff (RST)
    VECTOR_REQ && valid[promo_index] && !(|valid[127:122]) |=> VECTOR[7:1] == $past(promo_index))
    else $error("promoted source lost");
  a_normal_reads_zero: assert property (@(posedge REF_CLK) disable iff (RST)
    !SPECIAL_MODE |=> TEST_RDATA == 8'h00)
    else $error("test data visible outside special mode");
  a_wake_nonmask: assert property (@(posedge REF_CLK) disable iff (RST)
    NONMASKABLE_PIN_REQUEST && !test_input_override |-> WAKEUP)
    else $error("nonmaskable request gave no wake-up");

endmodule

/* cpu_core_model.sv */
`timescale 1ns/1ps
module cpu_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench command
  input wire logic go,
  // Vector answer from the decoder
  input wire logic vector_valid,
  input wire logic [15:0] vector,
  output logic vector_req,
  output logic [15:0] fetched,
  output int answers
);
  // Request strobe follows the command off the falling edge, so it is one cycle wide
  always @(negedge clk or posedge rst)
  begin
    if (rst)
      vector_req <= 1'b0;
    else
      vector_req <= go;
  end

  // Answer is taken mid-cycle, where it has settled; reset clears the count
  always @(negedge clk or posedge rst)
  begin
    if (rst)
    begin
      fetched <= 16'h0000;
      answers <= 0;
    end
    else if (vector_valid === 1'b1)
    begin
      fetched <= vector;
      answers <= answers + 1;
    end
  end
endmodule

/* exception_vector_priority_decoder_tb.sv */
`timescale 1ns/1ps
module exception_vector_priority_decoder_tb;
  // Bench-driven inputs; lines holds one bit per vector line
  logic clk = 0;
  logic rst = 1;
  logic spec = 0;
  logic imask = 0;
  logic xmask = 0;
  logic dbg = 0;
  logic go = 0;
  logic pwr = 0;
  logic [7:0] pwd = '0;
  logic [127:0] lines = '0;
  logic [10:0] tacc_s = '0;
  // Design and partner outputs
  logic vreq;
  logic vvalid;
  logic wake;
  logic pend;
  logic [15:0] vec;
  logic [15:0] exp_vec = '0;
  logic [15:0] fetched;
  logic [7:0] prd;
  logic [7:0] trd;
  int answers;
  // Reference model state: last valid line, promoted line, pending answers
  int last = 123;
  int promo = 121;
  int q[$];
  int mismatches = 0;
  int num_checks = 0;

  exception_vector_priority_decoder u_exception_vector_priority_decoder (
    .REF_CLK(clk), .RST(rst), .SPECIAL_MODE(spec), .I_MASK(imask), .X_MASK(xmask),
    .RESET_REQ(exc_vector_pkg::reset_req_t'(lines[127:125])), .TRAP_REQ(lines[124]),
    .SWI_REQ(lines[123]), .BACKGROUND_DEBUG_REQUEST(dbg), .NONMASKABLE_PIN_REQUEST(lines[122]),
    .IRQ_PIN_REQ(lines[121]), .PERIPH_REQ(lines[120:0]), .PROMO_WR(pwr), .PROMO_WDATA(pwd),
    .PROMO_RDATA(prd), .TEST_ACC(exc_vector_pkg::test_access_t'(tacc_s)), .TEST_RDATA(trd),
    .VECTOR_REQ(vreq), .VECTOR(vec), .VECTOR_VALID(vvalid), .INT_PENDING(pend), .WAKEUP(wake));

  cpu_core_model u_cpu_core_model (
    .clk(clk), .rst(rst), .go(go), .vector_valid(vvalid), .vector(vec),
    .vector_req(vreq), .fetched(fetched), .answers(answers));

  // 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Winning line from current inputs, -1 when nothing is valid
  function automatic int win();
    logic [127:0] v;
    int top;
    v = lines;
    v[123] = v[123] | dbg;
    v[122] = v[122] & !xmask;
    if (imask)
      v[121:0] = '0;
    top = -1;
    for (int i = 0; i < 128; i++)
      if (v[i])
        top = i;
    // Promoted line only beats other maskables, never the fixed sources
    if (top >= 0 && top <= 121 && v[promo])
      top = promo;
    return top;
  endfunction

  // Model: winner fixed at the request edge, else last valid line
  always @(posedge clk)
  begin
    if (rst)
      last = 123;
    else
    begin
      if (vreq === 1'b1)
        q.push_back(win() >= 0 ? win() : last);
      if (win() >= 0)
        last = win();
    end
  end

  // Every answer compared with the model
  always @(negedge clk)
  begin
    if (vvalid === 1'b1)
    begin
      exp_vec = {8'hff, 7'(q[0]), 1'b0};
      chk("vector", vec, exp_vec);
      void'(q.pop_front());
    end
  end

  // One vector request through the core model, answer bounded to a few cycles
  task automatic ask();
    int n;
    n = answers;
    @(posedge clk) go = 1;
    @(posedge clk) go = 0;
    repeat (3) @(negedge clk);
    chk("answers", 16'(answers), 16'(n + 1));
    chk("fetched", fetched, exp_vec);
  endtask

  // Selector write with maskables masked, then readback
  task automatic promo_wr(input logic [7:0] d);
    @(negedge clk);
    imask = 1;
    pwd = d;
    pwr = 1;
    @(negedge clk) pwr = 0;
    promo = d >= 8'hf2 ? 121 : int'(d[7:1]);
    repeat (2) @(negedge clk);
    chk("promo read", 16'(prd), {8'h00, d[7:1], 1'b0});
    imask = 0;
  endtask

  // One test access: {wr, rd, sel_bits, wdata}
  task automatic tacc(input logic [10:0] v);
    @(negedge clk) tacc_s = v;
    @(negedge clk) tacc_s = '0;
    @(negedge clk);
  endtask

  initial
  begin
    void'($urandom(91181));
    repeat (16) @(posedge clk);
    @(negedge clk) rst = 0;
    // Nothing ever pending
    ask();
    // Each fixed source alone, then debug request
    for (int i = 121; i < 128; i++)
    begin
      @(negedge clk) lines = 128'(1) << i;
      ask();
    end
    @(negedge clk);
    lines = '0;
    dbg = 1;
    ask();
    dbg = 0;
    // Higher request arriving late, then source gone, then masked nmi
    lines = 128'(1) << 121;
    repeat (3) @(negedge clk);
    lines[122] = 1;
    ask();
    @(negedge clk) lines = '0;
    ask();
    xmask = 1;
    lines[122] = 1;
    ask();
    $display("test fixed done");
    promo_wr(8'h80);
    // Random sparse requests with masks and promotion of line 64
    repeat (40)
    begin
      @(negedge clk);
      lines = '0;
      lines[$urandom_range(120, 0)] = 1;
      lines[64] = $urandom_range(1, 0);
      if ($urandom_range(3, 0) == 0)
        lines[$urandom_range(127, 121)] = 1;
      imask = $urandom_range(3, 0) == 0;
      xmask = $urandom_range(1, 0);
      ask();
    end
    // Out-of-range selector falls back to the pin
    promo_wr(8'hf4);
    lines = '0;
    lines[64] = 1;
    lines[100] = 1;
    ask();
    $display("test promotion done");
    // Test registers: override, forced bit, refused outside special mode
    lines = '0;
    imask = 1;
    xmask = 1;
    spec = 1;
    tacc({3'b100, 8'h1f});
    tacc({3'b101, 8'h02});
    tacc({3'b011, 8'h00});
    chk("test bits", 16'(trd), 16'h0002);
    spec = 0;
    tacc({3'b100, 8'h0f});
    spec = 1;
    tacc({3'b010, 8'h00});
    chk("test ctrl", 16'(trd), 16'h001f);
    tacc({3'b100, 8'h0f});
    lines[121] = 1;
    tacc({3'b011, 8'h00});
    chk("real bits", 16'(trd), 16'h0002);
    spec = 0;
    $display("test registers done");
    // Wake-up: masked maskable none, masked nmi still wakes
    @(negedge clk) lines = 128'(1) << 5;
    #1 chk("wake", 16'(wake), 16'h0000);
    @(negedge clk) lines = 128'(1) << 122;
    #1 chk("wake", 16'(wake), 16'h0001);
    // Pending flag lags a cycle: masked lines give none, unmasking the pin raises it
    chk("pending", 16'(pend), 16'h0000);
    @(negedge clk) xmask = 0;
    @(negedge clk) chk("pending", 16'(pend), 16'h0001);
    $display("test wakeup done");
    end_sim();
  end

  // Watchdog, far beyond the expected run of under a thousand cycles
  initial
  begin
    #200000;
    mismatches++;
    end_sim();
  end
endmodule
